// ---- inc/ssd_pkg.sv ----
// Notes on behaviour
// R01: stall check only when enabled by configuration
// R02: measure encoder pulse rate during moves
// R03: stall when measured below tenth of theoretical
// R04: stall stops step pulses, sets status bit
// R05: motion leaves only as step and direction
// R06: home, limits, index active when pulled low
// R07: emergency halt active when line high or open
// R08: quadrature count up when A leads B
// R09: theoretical rate from step rate times ratio
package ssd_pkg;
    // measurement window length in clock cycles (100 us at 100 MHz)
    localparam int unsigned CLK_HZ        = 100000000;
    localparam int unsigned WINDOW_US     = 100;
    localparam int unsigned WINDOW_CYCLES = CLK_HZ / 1000000 * WINDOW_US;
    localparam int unsigned CNT_W         = 24;
    localparam int unsigned POS_W         = 32;
    localparam logic [7:0]  MULT_RESET    = 8'h01;
    localparam logic [4:0]  DIV_RESET     = 5'h01;
    localparam int unsigned STALL_RATIO   = 10;
    // pin idle levels: encoder low, active-low switches high, halt low
    localparam logic [6:0]  PIN_IDLE      = 7'h1e;

    typedef struct packed {
        logic       stall_enable;
        logic       quadrature;
        logic [7:0] enc_multiplier;
        logic [4:0] enc_divisor;
    } ssd_cfg_type;

    typedef struct packed {
        logic home;
        logic lower_limit;
        logic upper_limit;
        logic index;
        logic emergency_halt;
    } ssd_switch_type;
endpackage

// ---- rtl/ssd_sync.sv ----
`timescale 1ns/1ps
module ssd_sync #(
    parameter int unsigned  W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    always_comb begin
        meta_next = d;
        q_next    = meta_reg;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= RST;
            q_reg    <= RST;
        end else begin
            meta_reg <= meta_next;
            q_reg    <= q_next;
        end
    end

    assign q = q_reg;
endmodule

// ---- rtl/ssd_top.sv ----
`timescale 1ns/1ps
module ssd_top (
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire ssd_pkg::ssd_cfg_type cfg,
    input  wire logic                step_req,
    input  wire logic                dir_req,
    input  wire logic                move_active,
    input  wire logic                clear_stall,
    input  wire logic                enc_a_pin,
    input  wire logic                enc_b_pin,
    input  wire logic                home_n_pin,
    input  wire logic                lower_travel_limit_input,
    input  wire logic                upper_travel_limit_input,
    input  wire logic                index_n_pin,
    input  wire logic                emergency_halt_input,
    output logic                     step_out,
    output logic                     dir_out,
    output logic                     stall_error_status_bit,
    output ssd_pkg::ssd_switch_type  switches,
    output logic [ssd_pkg::POS_W-1:0] enc_position
);
    import ssd_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    // reset to idle levels so no switch looks active just after reset
    logic [6:0] pins_sync;

    ssd_sync #(.W(7), .RST(PIN_IDLE)) u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .d      ({enc_a_pin, enc_b_pin, home_n_pin,
                  lower_travel_limit_input, upper_travel_limit_input,
                  index_n_pin, emergency_halt_input}),
        .q      (pins_sync)
    );

    logic enc_a;
    logic enc_b;
    assign enc_a = pins_sync[6];
    assign enc_b = pins_sync[5];

    ////////////////////////////////////////////////////////////////////
    // switch qualification
    // switches are active low, the halt line alone is active high
    ssd_switch_type sw_reg;
    ssd_switch_type sw_next;

    always_comb begin
        sw_next.home           = ~pins_sync[4]; // R06
        sw_next.lower_limit    = ~pins_sync[3]; // R06
        sw_next.upper_limit    = ~pins_sync[2]; // R06
        sw_next.index          = ~pins_sync[1]; // R06
        sw_next.emergency_halt = pins_sync[0];  // R07
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sw_reg <= '0;
        end else begin
            sw_reg <= sw_next;
        end
    end

    assign switches = sw_reg;

    ////////////////////////////////////////////////////////////////////
    // encoder decoding
    logic             a_reg;
    logic             a_next;
    logic             b_reg;
    logic             b_next;
    logic [POS_W-1:0] pos_reg;
    logic [POS_W-1:0] pos_next;
    logic             enc_pulse;

    always_comb begin
        a_next    = enc_a;
        b_next    = enc_b;
        pos_next  = pos_reg;
        enc_pulse = 1'b0;
        if (cfg.quadrature) begin
            // each edge of one channel alone is one count, a change on both at once none
            if ((enc_a ^ a_reg) || (enc_b ^ b_reg)) begin
                enc_pulse = 1'b1;
                if ((enc_a ^ b_reg) && !(enc_b ^ a_reg)) begin
                    pos_next = pos_reg + 1'b1; // R08
                end else if (!(enc_a ^ b_reg) && (enc_b ^ a_reg)) begin
                    pos_next = pos_reg - 1'b1; // R08
                end else begin
                    enc_pulse = 1'b0;
                end
            end
        end else begin
            if (enc_a && !a_reg) begin
                enc_pulse = 1'b1;
                pos_next  = pos_reg + 1'b1;
            end else if (enc_b && !b_reg) begin
                enc_pulse = 1'b1;
                pos_next  = pos_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            a_reg   <= 1'b0;
            b_reg   <= 1'b0;
            pos_reg <= '0;
        end else begin
            a_reg   <= a_next;
            b_reg   <= b_next;
            pos_reg <= pos_next;
        end
    end

    assign enc_position = pos_reg;

    ////////////////////////////////////////////////////////////////////
    // velocity windows and stall decision
    localparam logic [CNT_W-1:0] WIN_LAST = CNT_W'(WINDOW_CYCLES - 1);

    logic [CNT_W-1:0] win_reg;
    logic [CNT_W-1:0] win_next;
    logic [CNT_W-1:0] steps_reg;
    logic [CNT_W-1:0] steps_next;
    logic [CNT_W-1:0] pulses_reg;
    logic [CNT_W-1:0] pulses_next;
    logic             stall_reg;
    logic             stall_next;
    logic             step_d_reg;
    logic             step_d_next;
    logic             step_gate;
    logic [39:0]      theo_x_div;
    logic [39:0]      meas_scaled;

    // gating is combinational so a stall blocks the very next step edge
    assign step_gate = step_req & ~stall_reg; // R04

    // mult/div is steps per feedback pulse, so the theoretical pulse
    // count is steps*div/mult; cross-multiplied to avoid a divider:
    // measured*mult*10 < steps*div  <=>  measured < 10% of theoretical
    always_comb begin
        theo_x_div  = 40'(steps_reg) * 40'(cfg.enc_divisor); // R09
        meas_scaled = 40'(pulses_reg) * 40'(cfg.enc_multiplier)
                      * 40'(STALL_RATIO); // R03
    end

    always_comb begin
        win_next    = win_reg;
        steps_next  = steps_reg;
        pulses_next = pulses_reg;
        stall_next  = stall_reg;
        step_d_next = step_gate;
        // clear first so that a set in the same cycle wins
        if (clear_stall) begin
            stall_next = 1'b0;
        end
        if (!move_active || !cfg.stall_enable) begin // R01
            win_next    = '0;
            steps_next  = '0;
            pulses_next = '0;
        end else if (win_reg == WIN_LAST) begin
            // an edge on the closing cycle is counted in neither window
            win_next    = '0;
            steps_next  = '0;
            pulses_next = '0;
            if (meas_scaled < theo_x_div) begin // R03
                stall_next = 1'b1; // R04
            end
        end else begin
            win_next = win_reg + 1'b1;
            if (step_gate && !step_d_reg) begin
                steps_next = steps_reg + 1'b1;
            end
            if (enc_pulse) begin
                pulses_next = pulses_reg + 1'b1; // R02
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            win_reg    <= '0;
            steps_reg  <= '0;
            pulses_reg <= '0;
            stall_reg  <= 1'b0;
            step_d_reg <= 1'b0;
        end else begin
            win_reg    <= win_next;
            steps_reg  <= steps_next;
            pulses_reg <= pulses_next;
            stall_reg  <= stall_next;
            step_d_reg <= step_d_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // step and direction to the translator drive
    logic step_out_reg;
    logic step_out_next;
    logic dir_out_reg;
    logic dir_out_next;

    always_comb begin
        step_out_next = step_gate; // R05
        dir_out_next  = dir_req;   // R05
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            step_out_reg <= 1'b0;
            dir_out_reg  <= 1'b0;
        end else begin
            step_out_reg <= step_out_next;
            dir_out_reg  <= dir_out_next;
        end
    end

    assign step_out               = step_out_reg;
    assign dir_out                = dir_out_reg;
    assign stall_error_status_bit = stall_reg; // R04
endmodule

// ---- tb/ssd_drive_model.sv ----
`timescale 1ns/1ps
module ssd_drive_model (
    input  logic clk,
    input  logic arst_n,
    input  logic step,
    input  logic dir,
    input  logic quad,
    input  logic freeze,
    output logic enc_a,
    output logic enc_b
);
    logic [1:0] ph_reg, ph_next;
    logic       stp_reg, pls_reg, pls_next;
    // freeze models a stalled shaft: steps arrive, encoder stays still
    always_comb begin
        pls_next = step && !stp_reg && !freeze;
        ph_next = ph_reg;
        if (!quad) begin
            ph_next = 2'h0;
        end else if (pls_next) begin
            ph_next = dir ? ph_reg + 2'h1 : ph_reg - 2'h1;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ph_reg <= 2'h0;
            stp_reg <= 1'b0;
            pls_reg <= 1'b0;
        end else begin
            ph_reg <= ph_next;
            stp_reg <= step;
            pls_reg <= pls_next;
        end
    end
    assign enc_a = quad ? ph_reg[1] ^ ph_reg[0] : pls_reg & dir;
    assign enc_b = quad ? ph_reg[1] : pls_reg & !dir;
endmodule

// ---- tb/ssd_assertions.sv ----
`timescale 1ns/1ps
module ssd_assertions (
    input logic                   clk,
    input logic                   arst_n,
    input ssd_pkg::ssd_cfg_type    cfg,
    input logic                   step_req,
    input logic                   dir_req,
    input logic                   move_active,
    input logic                   clear_stall,
    input logic                   home_n_pin,
    input logic                   emergency_halt_input,
    input logic                   step_out,
    input logic                   dir_out,
    input logic                   stall_error_status_bit,
    input ssd_pkg::ssd_switch_type switches,
    input logic [ssd_pkg::POS_W-1:0] enc_position
);
    import ssd_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_stall_gate: assert property (
        $past(stall_error_status_bit) |-> !step_out)
        else $error("step while stalled");
    a_step_pass: assert property (
        step_req && !stall_error_status_bit |=> step_out)
        else $error("step not passed");
    a_dir_follow: assert property (
        1'b1 |=> dir_out == $past(dir_req))
        else $error("direction not passed");
    a_check_off: assert property (
        !cfg.stall_enable |=> !$rose(stall_error_status_bit))
        else $error("stall while disabled");
    a_move_only: assert property (
        !move_active |=> !$rose(stall_error_status_bit))
        else $error("stall outside move");
    a_stall_sticky: assert property (
        stall_error_status_bit && !clear_stall |=> stall_error_status_bit)
        else $error("stall dropped");
    a_home_low: assert property (
        $past(arst_n, 3) |-> switches.home == !$past(home_n_pin, 3))
        else $error("home polarity");
    a_halt_level: assert property (
        $past(arst_n, 3) |->
        switches.emergency_halt == $past(emergency_halt_input, 3))
        else $error("halt polarity");
    a_count_unit: assert property (
        $changed(enc_position) |->
        (enc_position - $past(enc_position)) inside {32'h1, 32'hffffffff})
        else $error("count jump");
endmodule
bind ssd_top ssd_assertions chk_u (.*);

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import ssd_pkg::*;
    logic             clk = 1'b0, arst_n = 1'b0, freeze = 1'b0, halt = 1'b0;
    logic             step_req = 1'b0, dir_req = 1'b0, move_active = 1'b0;
    logic             clear_stall = 1'b0, enc_a, enc_b;
    logic             step_out, dir_out, stall;
    logic [3:0]       sw_n = 4'hf;
    ssd_cfg_type      cfg = '{1'b0, 1'b0, 8'h01, 5'h01};
    ssd_switch_type   switches;
    logic [POS_W-1:0] pos, exp_pos = '0;
    int               err_count = 0, checked = 0, cycles = 0, i;
    int               seed = 32'h06de, r;
    always #5 clk = ~clk;
    ssd_top dut_u (.clk(clk), .arst_n(arst_n), .cfg(cfg), .step_req(step_req),
        .dir_req(dir_req), .move_active(move_active), .clear_stall(clear_stall),
        .enc_a_pin(enc_a), .enc_b_pin(enc_b), .home_n_pin(sw_n[3]),
        .lower_travel_limit_input(sw_n[2]), .upper_travel_limit_input(sw_n[1]),
        .index_n_pin(sw_n[0]), .emergency_halt_input(halt), .step_out(step_out),
        .dir_out(dir_out), .stall_error_status_bit(stall), .switches(switches),
        .enc_position(pos));
    ssd_drive_model drv_u (.clk(clk), .arst_n(arst_n), .step(step_out),
        .dir(dir_out), .quad(cfg.quadrature), .freeze(freeze), .enc_a(enc_a),
        .enc_b(enc_b));
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic step(input logic d);
        dir_req = d;
        tick(1);
        step_req = 1'b1;
        tick(2);
        step_req = 1'b0;
        tick(4);
        if (!freeze) exp_pos += d ? 32'h1 : 32'hffffffff;
    endtask
    function automatic ssd_switch_type exp_sw(input logic [3:0] n,
                                              input logic       h);
        return {~n, h};
    endfunction
    // one feedback pulse per step, so measured/theoretical is m/d;
    // a frozen shaft gives no pulses at all
    function automatic logic exp_stall(input logic       en,
                                       input logic       fz,
                                       input logic [7:0] m,
                                       input logic [4:0] d);
        return en && (fz || STALL_RATIO * m < d);
    endfunction
    // one move with supervision set up as given, then clear and stop
    task automatic stall_run(input logic       en,
                             input logic [7:0] m,
                             input logic [4:0] d,
                             input logic       fz);
        int n;
        cfg.stall_enable   = en;
        cfg.enc_multiplier = m;
        cfg.enc_divisor    = d;
        freeze             = fz;
        move_active        = 1'b1;
        // steps of 7 cycles each, enough to outlast one window
        for (n = 0; n < WINDOW_CYCLES / 7 + 100 && stall !== 1'b1; n++) begin
            step(1'b1);
        end
        cmp({31'h0, stall}, {31'h0, exp_stall(en, fz, m, d)});
        if (stall === 1'b1) begin
            step_req = 1'b1;
            tick(2);
            cmp({31'h0, step_out}, 32'h0);
            step_req = 1'b0;
        end
        clear_stall = 1'b1;
        move_active = 1'b0;
        tick(1);
        clear_stall = 1'b0;
        tick(1);
        cmp({31'h0, stall}, 32'h0);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            report_and_stop;
        end
    end
    initial begin
        tick(4);
        arst_n = 1'b1;
        tick(2);
        for (i = 0; i < 12; i++) begin
            r = (i < 2) ? {32{i[0]}} : $random(seed);
            {sw_n, halt} = r[4:0];
            tick(5);
            cmp({27'h0, switches}, {27'h0, exp_sw(sw_n, halt)});
        end
        // up/down feedback first, then quadrature, random directions
        for (i = 0; i < 40; i++) begin
            cfg.quadrature = (i >= 20);
            r = $random(seed);
            step(r[0] || i < 3);
            tick(3);
            cmp(pos, exp_pos);
        end
        // supervision off, then feedback at 11% and at 9% of the
        // theoretical rate, then a frozen shaft
        stall_run(1'b0, 8'h01, 5'h01, 1'b1);
        stall_run(1'b1, 8'h01, 5'h09, 1'b0);
        stall_run(1'b1, 8'h01, 5'h0b, 1'b0);
        stall_run(1'b1, 8'h01, 5'h01, 1'b1);
        report_and_stop;
    end
endmodule
